// File: include/bbie_pkg.sv
// bbie_pkg: register map, instruction fields, op codes and timing for the executor
package bbie_pkg;
  // register byte offsets on the avalon slave
  localparam logic [4:0] REG_INSTR  = 5'h00;  // write issues one instruction
  localparam logic [4:0] REG_ACC    = 5'h04;  // accumulator, low byte
  localparam logic [4:0] REG_STATUS = 5'h08;  // flags, skip and busy
  localparam logic [4:0] REG_FPTR   = 5'h0c;  // file register pointer for software access
  localparam logic [4:0] REG_FDATA  = 5'h10;  // file register at the pointer
  localparam logic [4:0] REG_CYCLES = 5'h14;  // instruction cycles retired
  // instruction word fields
  localparam int IMM_LSB  = 0;   // 8-bit immediate
  localparam int ADDR_LSB = 8;   // 7-bit file address
  localparam int DEST_POS = 15;  // 0 = accumulator, 1 = file register
  localparam int BIT_LSB  = 16;  // 3-bit bit index
  localparam int OP_LSB   = 20;  // 4-bit operation
  // status bit positions
  localparam int ST_ZERO = 0;
  localparam int ST_NIB  = 1;
  localparam int ST_CARRY = 2;
  localparam int ST_SKIP = 3;
  localparam int ST_BUSY = 4;
  // operation codes
  localparam logic [3:0] OP_NOP       = 4'h0;
  localparam logic [3:0] OP_ADD_IMM   = 4'h1;  // add_immediate_to_acc
  localparam logic [3:0] OP_ADD_FILE  = 4'h2;  // add_acc_to_file
  localparam logic [3:0] OP_AND_FILE  = 4'h3;  // and_acc_with_file
  localparam logic [3:0] OP_AND_IMM   = 4'h4;  // and_immediate_with_acc
  localparam logic [3:0] OP_BIT_CLR   = 4'h5;  // bit_clear_in_file
  localparam logic [3:0] OP_BIT_SET   = 4'h6;  // bit_set_in_file
  localparam logic [3:0] OP_TEST_ONE  = 4'h7;  // test_bit_skip_when_one
  localparam logic [3:0] OP_TEST_ZERO = 4'h8;  // test_bit_skip_when_zero
  localparam logic [3:0] OP_ZERO_FILE = 4'h9;  // zero_file_register
  // reset values
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [31:0] INSTR_RST = 32'h0000_0000;
  // timing: one instruction cycle is four mclk periods
  localparam int MCLK_PERIOD_NS = 50;
  localparam int TCY_NS         = 200;
  localparam int TCY_CLKS       = TCY_NS / MCLK_PERIOD_NS;
  localparam logic [1:0] RD_WAIT = 2'h2;  // wait cycles before a read answers
endpackage

// File: hdl/bbie_file_ram.sv
// bbie_file_ram: file register memory, one write port, registered read data
module bbie_file_ram #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  // clock and reset
  input  wire  logic          mclk,
  input  wire  logic          rst_n,
  input  wire  logic          ce,
  // read port
  input  wire  logic [AW-1:0] raddr,
  output logic       [7:0]    rdata,
  // write port
  input  wire  logic          we,
  input  wire  logic [AW-1:0] waddr,
  input  wire  logic [7:0]    wdata
);
  import bbie_pkg::*;

  // whole memory plus read register as one state word
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0]            rdata;
  } bbie_ram_s;

  bbie_ram_s s_r;
  bbie_ram_s s_nxt;

  // read is registered so address decode never reaches the output
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = s_r.mem[raddr];
    if (we) begin
      s_nxt.mem[waddr] = wdata;
    end
  end

  // cleared at reset so reads are never unknown
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
endmodule

// File: hdl/bbie_exec.sv
// bbie_exec: byte and bit instruction executor with an avalon-mm register slave
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
module bbie_exec (
  // clock, enable and reset
  input  wire  logic        mclk,
  input  wire  logic        ce,
  input  wire  logic        reset_n,
  // avalon-mm slave
  input  wire  logic [4:0]  avs_address,
  input  wire  logic        avs_read,
  input  wire  logic        avs_write,
  input  wire  logic [3:0]  avs_byteenable,
  input  wire  logic [31:0] avs_writedata,
  output logic       [31:0] avs_readdata,
  output logic              avs_waitrequest,
  // execution status
  output logic              busy,
  output logic              skip_pending
);
  import bbie_pkg::*;

  // one state per mclk period of the instruction cycle
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_READ, S_CALC, S_COMMIT} bbie_st_e;

  typedef struct packed {
    bbie_st_e    st;      // phase of the instruction cycle
    logic [31:0] instr;   // instruction being executed
    logic [7:0]  acc;     // accumulator
    logic        zero;    // zero flag
    logic        nib;     // nibble_overflow_flag
    logic        carry;   // carry flag
    logic        skip;    // next instruction is to be discarded
    logic [6:0]  fptr;    // software file pointer
    logic [31:0] cycles;  // retired instruction cycles
    logic [1:0]  rd_cnt;  // read wait counter
    logic [31:0] rdata;   // registered read data
  } bbie_state_s;

  bbie_state_s s_r;
  bbie_state_s s_nxt;
  logic [1:0]  rst_sync_r;  // reset release synchroniser
  logic        rst_n_i;     // synchronised reset

  // release the async reset through two flops to avoid metastable exit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_i = rst_sync_r[1];

  // decoded instruction fields
  logic [3:0] op;
  logic [7:0] imm;
  logic [6:0] faddr;
  logic       dest;
  logic [2:0] bidx;
  assign op    = s_r.instr[OP_LSB +: 4];
  assign imm   = s_r.instr[IMM_LSB +: 8];
  assign faddr = s_r.instr[ADDR_LSB +: 7];
  assign dest  = s_r.instr[DEST_POS];
  assign bidx  = s_r.instr[BIT_LSB +: 3];

  // memory ports
  logic [6:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic       mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;

  // pointer while idle so software reads see it; instruction address when busy
  assign mem_raddr = (s_r.st == S_IDLE) ? s_r.fptr : faddr;

  bbie_file_ram #(.DEPTH(128), .AW(7)) u_ram (
    .mclk  (mclk),
    .rst_n (rst_n_i),
    .ce    (ce),
    .raddr (mem_raddr),
    .rdata (mem_rdata),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata)
  );

  // datapath: operand, adder, nibble adder, and, bit mask
  logic [7:0] opnd;
  logic [8:0] sum;
  logic [4:0] nsum;
  logic [7:0] andv;
  logic [7:0] mask;
  logic       tbit;
  assign opnd = (op == OP_ADD_IMM || op == OP_AND_IMM) ? imm : mem_rdata;
  assign sum  = {1'b0, s_r.acc} + {1'b0, opnd};
  assign nsum = {1'b0, s_r.acc[3:0]} + {1'b0, opnd[3:0]};
  assign andv = s_r.acc & opnd;
  assign mask = 8'h01 << bidx;
  assign tbit = mem_rdata[bidx];

  // merge enabled byte lanes of a write into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // status word as software sees it
  logic [31:0] status_w;
  assign status_w = {27'h0, (s_r.st != S_IDLE), s_r.skip, s_r.carry, s_r.nib, s_r.zero};

  // next-state logic: bus slave when idle, instruction cycle when busy
  always_comb begin
    logic [31:0] wv;
    wv = 32'h0;
    s_nxt = s_r;
    mem_we = 1'b0;
    mem_waddr = faddr;
    mem_wdata = 8'h00;
    avs_waitrequest = 1'b1;
    case (s_r.st)
      S_IDLE: begin
        // every access stalls while busy; writes land in one cycle
        if (avs_write) begin
          avs_waitrequest = 1'b0;
          case ({avs_address[4:2], 2'b00})
            REG_INSTR: begin
              s_nxt.instr = lane_merge(s_r.instr, avs_writedata, avs_byteenable);
              s_nxt.st = S_FETCH;
            end
            REG_ACC: begin
              wv = lane_merge({24'h0, s_r.acc}, avs_writedata, avs_byteenable);
              s_nxt.acc = wv[7:0];
            end
            REG_STATUS: begin
              // flags only; skip and busy are hardware state
              if (avs_byteenable[0]) begin
                s_nxt.zero  = avs_writedata[ST_ZERO];
                s_nxt.nib   = avs_writedata[ST_NIB];
                s_nxt.carry = avs_writedata[ST_CARRY];
              end
            end
            REG_FPTR: begin
              if (avs_byteenable[0]) begin
                s_nxt.fptr = avs_writedata[6:0];
              end
            end
            REG_FDATA: begin
              mem_we = avs_byteenable[0];
              mem_waddr = s_r.fptr;
              mem_wdata = avs_writedata[7:0];
            end
            default: begin
              // unmapped write is accepted and dropped
            end
          endcase
        end else if (avs_read) begin
          // two wait cycles so the memory read register has settled
          if (s_r.rd_cnt == RD_WAIT) begin
            avs_waitrequest = 1'b0;
            s_nxt.rd_cnt = 2'h0;
          end else begin
            s_nxt.rd_cnt = s_r.rd_cnt + 2'h1;
            if (s_r.rd_cnt == RD_WAIT - 2'h1) begin
              case ({avs_address[4:2], 2'b00})
                REG_INSTR:  s_nxt.rdata = s_r.instr;
                REG_ACC:    s_nxt.rdata = {24'h0, s_r.acc};
                REG_STATUS: s_nxt.rdata = status_w;
                REG_FPTR:   s_nxt.rdata = {25'h0, s_r.fptr};
                REG_FDATA:  s_nxt.rdata = {24'h0, mem_rdata};
                REG_CYCLES: s_nxt.rdata = s_r.cycles;
                default:    s_nxt.rdata = 32'h0;
              endcase
            end
          end
        end
      end
      // address goes out in the first period, data are back by the second
      S_FETCH: s_nxt.st = S_READ;
      S_READ:  s_nxt.st = S_CALC;
      S_CALC:  s_nxt.st = S_COMMIT;
      S_COMMIT: begin
        s_nxt.st = S_IDLE;
        s_nxt.cycles = s_r.cycles + 32'h1;
        if (s_r.skip) begin
          // discarded instruction runs as a nop for a full cycle
          s_nxt.skip = 1'b0;
        end else begin
          case (op)
            OP_ADD_IMM, OP_ADD_FILE: begin
              s_nxt.carry = sum[8];
              s_nxt.nib   = nsum[4];
              s_nxt.zero  = (sum[7:0] == 8'h00);
              if (op == OP_ADD_FILE && dest) begin
                mem_we = 1'b1;
                mem_wdata = sum[7:0];
              end else begin
                s_nxt.acc = sum[7:0];
              end
            end
            OP_AND_FILE, OP_AND_IMM: begin
              s_nxt.zero = (andv == 8'h00);
              if (op == OP_AND_FILE && dest) begin
                mem_we = 1'b1;
                mem_wdata = andv;
              end else begin
                s_nxt.acc = andv;
              end
            end
            OP_BIT_CLR: begin
              mem_we = 1'b1;
              mem_wdata = mem_rdata & ~mask;
            end
            OP_BIT_SET: begin
              mem_we = 1'b1;
              mem_wdata = mem_rdata | mask;
            end
            OP_TEST_ONE:  s_nxt.skip = tbit;
            OP_TEST_ZERO: s_nxt.skip = ~tbit;
            OP_ZERO_FILE: begin
              mem_we = 1'b1;
              mem_wdata = 8'h00;
              s_nxt.zero = 1'b1;
            end
            default: begin
              // nop and unused codes change nothing
            end
          endcase
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
    // frozen clock enable must not let a bus cycle complete
    if (!ce) begin
      avs_waitrequest = 1'b1;
      mem_we = 1'b0;
    end
  end

  // single state register; clock enable freezes everything
  always_ff @(posedge mclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{st: S_IDLE, instr: INSTR_RST, acc: ACC_RST, default: '0};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = s_r.rdata;
  assign busy         = (s_r.st != S_IDLE);
  assign skip_pending = s_r.skip;

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_i);

  logic       commit;    // an instruction executes this cycle
  logic       live;      // executes and is not discarded
  logic [8:0] ref_add;   // independent adder reference
  logic [2:0] ph_cnt;    // enabled clocks since issue
  assign commit  = ce && (s_r.st == S_COMMIT);
  assign live    = commit && !s_r.skip;
  assign ref_add = 9'(s_r.acc) + 9'(opnd);

  // counts enabled clocks of the instruction cycle, checker only
  always_ff @(posedge mclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_cnt <= 3'h0;
    end else if (ce) begin
      ph_cnt <= (s_r.st == S_IDLE) ? 3'h0 : ph_cnt + 3'h1;
    end
  end

  a_add_imm_acc: assert property (live && op == OP_ADD_IMM |=>
    {s_r.carry, s_r.acc} == $past(ref_add)) else $error("immediate add wrong");
  a_add_file_dest: assert property (live && op == OP_ADD_FILE && dest |->
    mem_we && mem_wdata == ref_add[7:0] ##1 s_r.acc == $past(s_r.acc))
    else $error("file add destination wrong");
  a_and_flags_kept: assert property (live && op == OP_AND_FILE |=>
    $stable(s_r.carry) && $stable(s_r.nib)) else $error("and touched carries");
  a_and_imm_zero: assert property (live && op == OP_AND_IMM && (s_r.acc & imm) == 8'h00 |=>
    s_r.zero && s_r.acc == 8'h00) else $error("and immediate zero wrong");
  a_bit_clear: assert property (live && op == OP_BIT_CLR |->
    mem_we && !mem_wdata[bidx] ##1 $stable(s_r.zero)) else $error("bit clear wrong");
  a_bit_set: assert property (live && op == OP_BIT_SET |->
    mem_we && mem_wdata[bidx] && mem_waddr == faddr) else $error("bit set wrong");
  a_skip_one: assert property (live && op == OP_TEST_ONE |=>
    s_r.skip == $past(tbit) && $stable(s_r.zero)) else $error("skip on one wrong");
  a_skip_zero: assert property (live && op == OP_TEST_ZERO |=>
    s_r.skip == !$past(tbit)) else $error("skip on zero wrong");
  a_skip_nop: assert property (commit && s_r.skip |-> !mem_we ##1
    !s_r.skip && $stable(s_r.acc)) else $error("discarded instruction acted");
  a_zero_file: assert property (live && op == OP_ZERO_FILE |->
    mem_we && mem_wdata == 8'h00 ##1 s_r.zero) else $error("clear file wrong");
  a_cycle_four: assert property (commit |-> ph_cnt == 3'(TCY_CLKS - 1))
    else $error("instruction cycle not four clocks");
  a_nibble_carry: assert property (live && op == OP_ADD_FILE && !dest |=>
    s_r.nib == $past(nsum[4]) && s_r.zero == ($past(ref_add[7:0]) == 8'h00))
    else $error("add flags wrong");

  c_add_carry: cover property (live && op == OP_ADD_IMM && ref_add[8]);
  c_skip_taken: cover property (commit && s_r.skip);
  c_file_write: cover property (live && op == OP_AND_FILE && dest);
  c_read_fdata: cover property (avs_read && !avs_waitrequest && avs_address == REG_FDATA);
endmodule

// File: tb/bbie_exec_tb.sv
// bbie_exec_tb: table-driven bench for the byte and bit instruction executor
module bbie_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bbie_pkg::*;
  // one table row: the fields of one instruction
  typedef struct {
    logic [3:0] op;
    logic [2:0] b;
    logic       d;
    logic [6:0] a;
    logic [7:0] k;
  } bbie_row_s;
  logic        mclk = 1'b0;       // 20 mhz core clock
  logic        ce = 1'b1;         // held high except in the clock enable test
  logic        reset_n = 1'b0;    // async reset, active low
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'hf;  // whole words only
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        busy;
  logic        skip_pending;
  int          n_mismatch = 0;    // mismatches seen
  int          n_compared = 0;    // comparisons made
  int          bcnt = 0;          // clocks seen with busy high
  bbie_row_s   rows [0:19];       // ordinary cases
  logic [7:0]  acc_m;             // reference accumulator
  logic [7:0]  mem_m [0:127];     // reference file registers
  logic        z_m, dc_m, c_m, skip_m;  // reference flags
  logic [31:0] rd;                // last read data
  bbie_exec dut (.mclk(mclk), .ce(ce), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .busy(busy), .skip_pending(skip_pending));
  // clock generator
  always #25 mclk = ~mclk;
  // busy is sampled mid-cycle, away from the launching edge
  always @(negedge mclk) if (busy === 1'b1) bcnt++;
  // verdict and end of run
  task test_done;
    $display("counts: %0d compared, %0d mismatches", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // single comparison point
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // avalon write: called just after a rising edge, held until waitrequest is low at one
  task av_wr(input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  // avalon read: data taken at the very edge that sees waitrequest low
  task av_rd(input logic [4:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  // preload one file register, in the design and in the reference
  task fset(input logic [6:0] a, input logic [7:0] v);
    av_wr(REG_FPTR, {25'h0, a});
    av_wr(REG_FDATA, {24'h0, v});
    mem_m[a] = v;
  endtask
  // reference execution; a pending skip turns the row into a nop
  task mexec(input bbie_row_s r);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] v, res;
    v = (r.op == OP_ADD_IMM || r.op == OP_AND_IMM) ? r.k : mem_m[r.a];
    if (skip_m) skip_m = 1'b0;
    else case (r.op)
      OP_ADD_IMM, OP_ADD_FILE: begin
        s = {1'b0, acc_m} + {1'b0, v};
        n = {1'b0, acc_m[3:0]} + {1'b0, v[3:0]};
        {c_m, dc_m, z_m} = {s[8], n[4], s[7:0] == 8'h00};
        if (r.op == OP_ADD_FILE && r.d) mem_m[r.a] = s[7:0];
        else acc_m = s[7:0];
      end
      OP_AND_IMM, OP_AND_FILE: begin
        res = acc_m & v;
        z_m = (res == 8'h00);
        if (r.op == OP_AND_FILE && r.d) mem_m[r.a] = res;
        else acc_m = res;
      end
      OP_BIT_CLR: mem_m[r.a][r.b] = 1'b0;
      OP_BIT_SET: mem_m[r.a][r.b] = 1'b1;
      OP_TEST_ONE: skip_m = mem_m[r.a][r.b];
      OP_TEST_ZERO: skip_m = ~mem_m[r.a][r.b];
      OP_ZERO_FILE: begin
        mem_m[r.a] = 8'h00;
        z_m = 1'b1;
      end
      default: ;
    endcase
  endtask
  // wait for the instruction cycle to end, bounded
  task wait_idle;
    @(negedge mclk);
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge mclk);
    @(posedge mclk);
  endtask
  // issue one instruction and check its length in clocks
  task run(input bbie_row_s r);
    int b0;
    b0 = bcnt;
    av_wr(REG_INSTR, {8'h00, r.op, 1'b0, r.b, r.d, r.a, r.k});
    wait_idle();
    chk("busy_clocks", 32'(bcnt - b0), 32'(TCY_CLKS));
    mexec(r);
  endtask
  // compare visible state against the reference
  task chk_state(input logic [6:0] a);
    av_rd(REG_ACC, rd);
    chk("acc", {24'h0, rd[7:0]}, {24'h0, acc_m});
    av_rd(REG_STATUS, rd);
    chk("flags", {29'h0, rd[2:0]}, {29'h0, c_m, dc_m, z_m});
    chk("skip", {30'h0, rd[3], skip_pending}, {30'h0, skip_m, skip_m});
    av_wr(REG_FPTR, {25'h0, a});
    av_rd(REG_FDATA, rd);
    chk("file", {24'h0, rd[7:0]}, {24'h0, mem_m[a]});
  endtask
  // watchdog, well past the expected run length
  initial begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    test_done();
  end
  // main sequence
  initial begin
    rows[0] = '{OP_ADD_IMM, 3'h0, 1'b0, 7'h00, 8'h0f};
    rows[1] = '{OP_ADD_IMM, 3'h0, 1'b0, 7'h00, 8'hf1};
    rows[2] = '{OP_ADD_IMM, 3'h0, 1'b0, 7'h00, 8'hff};
    rows[3] = '{OP_ADD_FILE, 3'h0, 1'b0, 7'h7f, 8'h00};
    rows[4] = '{OP_ADD_FILE, 3'h0, 1'b1, 7'h05, 8'h00};
    rows[5] = '{OP_AND_FILE, 3'h0, 1'b0, 7'h05, 8'h00};
    rows[6] = '{OP_AND_FILE, 3'h0, 1'b1, 7'h00, 8'h00};
    rows[7] = '{OP_AND_IMM, 3'h0, 1'b0, 7'h00, 8'hc5};
    rows[8] = '{OP_ADD_IMM, 3'h0, 1'b0, 7'h00, 8'h80};
    rows[9] = '{OP_BIT_CLR, 3'h7, 1'b0, 7'h7f, 8'h00};
    rows[10] = '{OP_BIT_SET, 3'h0, 1'b0, 7'h00, 8'h00};
    rows[11] = '{OP_TEST_ONE, 3'h0, 1'b0, 7'h00, 8'h00};
    rows[12] = '{OP_ZERO_FILE, 3'h0, 1'b0, 7'h7f, 8'h00};
    rows[13] = '{OP_TEST_ONE, 3'h7, 1'b0, 7'h7f, 8'h00};
    rows[14] = '{OP_TEST_ZERO, 3'h0, 1'b0, 7'h00, 8'h00};
    rows[15] = '{OP_TEST_ZERO, 3'h0, 1'b0, 7'h05, 8'h00};
    rows[16] = '{OP_ADD_IMM, 3'h0, 1'b0, 7'h00, 8'h01};
    rows[17] = '{OP_ZERO_FILE, 3'h0, 1'b0, 7'h05, 8'h00};
    rows[18] = '{4'hf, 3'h0, 1'b0, 7'h00, 8'h55};
    rows[19] = '{OP_AND_IMM, 3'h0, 1'b0, 7'h00, 8'hff};
    foreach (mem_m[i]) mem_m[i] = 8'h00;
    {acc_m, z_m, dc_m, c_m, skip_m} = '0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    fset(7'h7f, 8'hff);
    fset(7'h05, 8'h3c);
    fset(7'h00, 8'h81);
    foreach (rows[i]) begin
      run(rows[i]);
      chk_state(rows[i].a);
    end
    av_rd(REG_CYCLES, rd);
    chk("cycles", {24'h0, rd[7:0]}, 32'h14);
    $display("table test done");
    // back to back: the second write waits out the first cycle
    av_wr(REG_ACC, 32'h10);
    acc_m = 8'h10;
    av_wr(REG_INSTR, {8'h00, OP_ADD_IMM, 12'h000, 8'h05});
    av_wr(REG_INSTR, {8'h00, OP_AND_IMM, 12'h000, 8'h0c});
    wait_idle();
    mexec('{OP_ADD_IMM, 3'h0, 1'b0, 7'h00, 8'h05});
    mexec('{OP_AND_IMM, 3'h0, 1'b0, 7'h00, 8'h0c});
    chk_state(7'h00);
    $display("back to back test done");
    // a status write must not cancel a pending skip
    fset(7'h10, 8'h01);
    run('{OP_TEST_ONE, 3'h0, 1'b0, 7'h10, 8'h00});
    av_wr(REG_STATUS, 32'h0);
    {c_m, dc_m, z_m} = 3'b000;
    chk_state(7'h10);
    run('{OP_BIT_CLR, 3'h0, 1'b0, 7'h10, 8'h00});
    chk_state(7'h10);
    av_rd(5'h18, rd);
    chk("unmapped", rd, 32'h0);
    $display("skip and unmapped test done");
    // a low enable stretches the cycle and loses no state
    av_wr(REG_INSTR, {8'h00, OP_ADD_IMM, 12'h000, 8'h01});
    ce <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("frozen_busy", {31'h0, busy}, 32'h1);
    ce <= 1'b1;
    wait_idle();
    mexec('{OP_ADD_IMM, 3'h0, 1'b0, 7'h00, 8'h01});
    chk_state(7'h00);
    $display("clock enable test done");
    // reset while idle, after the instruction cycle has ended, with a skip pending
    run('{OP_TEST_ONE, 3'h0, 1'b0, 7'h10, 8'h00});
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("busy_rst", {31'h0, busy}, 32'h0);
    chk("skip_rst", {31'h0, skip_pending}, 32'h0);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    foreach (mem_m[i]) mem_m[i] = 8'h00;
    {acc_m, z_m, dc_m, c_m, skip_m} = '0;
    chk_state(7'h10);
    $display("reset test done");
    test_done();
  end
endmodule
